// [rtl/ssr_pkg.sv]
// Purpose: shared constants and types of the serial sram front end
// Assumes: one system clock; the serial link is sampled, not clocked
// Notes:   command codes and mode codes are fixed by the link protocol
`default_nettype none
package ssr_pkg;
   // -------------------------------------------------------------
   // geometry and field lengths
   // -------------------------------------------------------------
   localparam int       SSR_ADDR_W   = 19;     // 512k bytes, two dies
   localparam int       SSR_PAGE_W   = 5;      // 32-byte page
   localparam logic [4:0] SSR_CMD_BITS  = 5'h08;
   localparam logic [4:0] SSR_ADDR_BITS = 5'h18;
   localparam logic [4:0] SSR_DATA_BITS = 5'h08;
   localparam int       SSR_DUMMY_CLKS = 4;    // dual read latency
   localparam logic [4:0] SSR_DUMMY_BITS = 5'(SSR_DUMMY_CLKS * 2);
   localparam int       SSR_SCK_HALF  = 8;     // sys_clk per sck half
   localparam int       SSR_FIFO_DEPTH = 8;
   // -------------------------------------------------------------
   // commands and access modes
   // -------------------------------------------------------------
   localparam logic [7:0] CMD_READ   = 8'h03;
   localparam logic [7:0] CMD_WRITE  = 8'h02;
   localparam logic [7:0] CMD_DUAL   = 8'h3b;
   localparam logic [7:0] CMD_QUAD   = 8'h38;
   localparam logic [7:0] CMD_EXIT   = 8'hff;
   localparam logic [7:0] CMD_RD_MODE = 8'h05;
   localparam logic [7:0] CMD_WR_MODE = 8'h01;
   localparam logic [1:0] MODE_BYTE  = 2'h0;
   localparam logic [1:0] MODE_PAGE  = 2'h2;
   localparam logic [1:0] MODE_SEQ   = 2'h1;
   localparam logic [1:0] MODE_RST   = MODE_SEQ;
   typedef enum logic [1:0] {LANE_SINGLE, LANE_DUAL, LANE_QUAD} ssr_lane_t;
endpackage : ssr_pkg
`default_nettype wire

// [rtl/ssr_link_if.sv]
// Purpose: pins between host end and sram end
// Assumes: every lane pin is pulled high when nobody drives it
// Notes:   enables are active low; the wire level is resolved here
`default_nettype none
interface ssr_link_if;
   logic       cs_n;       // chip select, low selects
   logic       sck;        // serial clock from host
   logic [3:0] host_o;     // host lane drive values
   logic [3:0] host_oe_n;  // host lane enables
   logic [3:0] dev_o;      // device lane drive values
   logic [3:0] dev_oe_n;   // device lane enables
   logic [3:0] lane;       // resolved io_lane3..io_lane0

   // wired level: driven value, else pull-up
   assign lane = (~dev_oe_n & dev_o) | (~host_oe_n & host_o)
               | (dev_oe_n & host_oe_n);

   modport host (output cs_n, output sck, output host_o,
                 output host_oe_n, input lane);
   modport dev  (input cs_n, input sck, input lane,
                 output dev_o, output dev_oe_n);
endinterface : ssr_link_if
`default_nettype wire

// [rtl/ssr_host_end.sv]
// Purpose: host controller end of the serial sram link, with write fifo
// Assumes: SCK_HALF at least 8 so read data settles before sampling
// Notes:   host stalls sck low while write data is due and the write fifo is empty
`default_nettype none
module ssr_fifo #(
   parameter int W     = 8,
   parameter int DEPTH = 8
) (
   input  wire logic         sys_clk,
   input  wire logic         rst,
   // fill side
   input  wire logic         in_valid,
   output logic              in_ready,
   input  wire logic [W-1:0] in_data,
   // drain side
   output logic              out_valid,
   input  wire logic         out_ready,
   output logic [W-1:0]      out_data
);
   localparam int PW = $clog2(DEPTH);
   logic [W-1:0] mem_r [0:DEPTH-1];
   logic [PW:0]  wp_r, wp_nxt, rp_r, rp_nxt;
   logic         push, pop;

   // -------------------------------------------------------------
   // pointers with a wrap bit give honest full and empty
   // -------------------------------------------------------------
   assign in_ready  = (wp_r[PW-1:0] != rp_r[PW-1:0]) || (wp_r[PW] == rp_r[PW]);
   assign out_valid = wp_r != rp_r;
   assign out_data  = mem_r[rp_r[PW-1:0]];
   assign push      = in_valid & in_ready;
   assign pop       = out_valid & out_ready;

   always_comb begin
      wp_nxt = wp_r + (PW+1)'(push);
      rp_nxt = rp_r + (PW+1)'(pop);
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         wp_r <= '0;
         rp_r <= '0;
      end else begin
         wp_r <= wp_nxt;
         rp_r <= rp_nxt;
      end
   end

   // storage, no reset needed
   always_ff @(posedge sys_clk) begin
      if (push) begin
         mem_r[wp_r[PW-1:0]] <= in_data;
      end
   end
endmodule : ssr_fifo

module ssr_host_end import ssr_pkg::*; #(
   parameter int SCK_HALF = SSR_SCK_HALF,
   parameter int DEPTH    = SSR_FIFO_DEPTH
) (
   // clock and reset
   input  wire logic        sys_clk,
   input  wire logic        rst,
   // link pins
   ssr_link_if.host         link,
   // command request
   input  wire logic        req_valid,
   output logic             req_ready,
   input  wire logic [7:0]  req_cmd,
   input  wire logic [23:0] req_addr,
   input  wire logic [7:0]  req_len,
   // write data in
   input  wire logic        wr_valid,
   output logic             wr_ready,
   input  wire logic [7:0]  wr_data,
   // read data out and pause
   output logic             rd_valid,
   output logic [7:0]       rd_data,
   input  wire logic        hold_req,
   output ssr_lane_t        lane_mode
);
   typedef enum logic [1:0] {H_IDLE, H_RUN, H_END} ssr_hst_t;
   typedef enum logic [1:0] {S_CMD, S_ADDR, S_DUMMY, S_DATA} ssr_seg_t;
   ssr_hst_t  st_r, st_nxt;
   ssr_seg_t  seg_r, seg_nxt;
   ssr_lane_t lane_r, lane_nxt;
   logic [7:0]  div_r, div_nxt, len_r, len_nxt, cmd_r, cmd_nxt;
   logic [7:0]  rx_r, rx_nxt, rdd_r, rdd_nxt;
   logic [31:0] sh_r, sh_nxt;
   logic [23:0] addr_r, addr_nxt;
   logic [4:0]  left_r, left_nxt, w;
   logic sck_r, sck_nxt, rd_r, rd_nxt, need_r, need_nxt;
   logic hold_r, hold_nxt, rdv_r, rdv_nxt, f_valid, f_pop;
   logic [7:0]  f_data;
   logic [3:0]  meta_r, ls_r, en;
   logic        drive;

   ssr_fifo #(.W(8), .DEPTH(DEPTH)) u_fifo (
      .sys_clk   (sys_clk),
      .rst       (rst),
      .in_valid  (wr_valid),
      .in_ready  (wr_ready),
      .in_data   (wr_data),
      .out_valid (f_valid),
      .out_ready (f_pop),
      .out_data  (f_data)
   );

   // -------------------------------------------------------------
   // pin drive; chip select high from reset onward
   // -------------------------------------------------------------
   assign req_ready = st_r == H_IDLE;
   assign rd_valid  = rdv_r;
   assign rd_data   = rdd_r;
   assign lane_mode = lane_r;
   assign link.cs_n = st_r != H_RUN;
   assign link.sck  = sck_r;
   assign drive = (st_r == H_RUN) && (seg_r != S_DUMMY)
               && !(seg_r == S_DATA && rd_r);
   always_comb begin
      w  = 5'h01;
      en = 4'h0;
      link.host_o = {~hold_r, 2'h3, sh_r[31]};
      case (lane_r)
         LANE_DUAL: begin
            w  = 5'h02;
            link.host_o = {~hold_r, 1'b1, sh_r[31:30]};
            en = {st_r == H_RUN, 1'b0, drive, drive};
         end
         LANE_QUAD: begin
            w  = 5'h04;
            link.host_o = sh_r[31:28];
            en = {4{drive}};
         end
         default: begin
            en = {st_r == H_RUN, 2'h0, st_r == H_RUN};
         end
      endcase
      link.host_oe_n = ~en;
   end

   // -------------------------------------------------------------
   // sequencer: sck generation, segments, pause and stall
   // -------------------------------------------------------------
   always_comb begin
      st_nxt = st_r; seg_nxt = seg_r; lane_nxt = lane_r;
      div_nxt = div_r; len_nxt = len_r; cmd_nxt = cmd_r;
      rx_nxt = rx_r; rdd_nxt = rdd_r; sh_nxt = sh_r;
      addr_nxt = addr_r; left_nxt = left_r; sck_nxt = sck_r;
      rd_nxt = rd_r; need_nxt = need_r; hold_nxt = hold_r;
      rdv_nxt = 1'b0; f_pop = 1'b0;
      case (st_r)
         H_IDLE: begin
            if (req_valid) begin
               cmd_nxt = req_cmd; addr_nxt = req_addr; len_nxt = req_len;
               sh_nxt = {req_cmd, 24'h0}; left_nxt = SSR_CMD_BITS;
               seg_nxt = S_CMD; st_nxt = H_RUN; div_nxt = 8'h00;
            end
         end
         H_RUN: begin
            div_nxt = div_r + 8'h01;
            if (div_r == 8'(SCK_HALF - 1)) begin
               div_nxt = 8'h00;
               if (!sck_r) begin
                  // pause and resume only change with sck low
                  if (hold_req && lane_r != LANE_QUAD) begin
                     hold_nxt = 1'b1;
                  end else if (hold_r) begin
                     hold_nxt = 1'b0;
                  end else if (need_r) begin
                     if (f_valid) begin
                        sh_nxt = {f_data, 24'h0}; f_pop = 1'b1;
                        need_nxt = 1'b0;
                     end
                  end else begin
                     sck_nxt = 1'b1;
                     case (lane_r)
                        LANE_DUAL: rx_nxt = {rx_r[5:0], ls_r[1:0]};
                        LANE_QUAD: rx_nxt = {rx_r[3:0], ls_r};
                        default:   rx_nxt = {rx_r[6:0], ls_r[1]};
                     endcase
                  end
               end else begin
                  sck_nxt = 1'b0;
                  sh_nxt = sh_r << w;
                  left_nxt = left_r - w;
                  if (left_r == w) begin
                     case (seg_r)
                        S_CMD: begin
                           seg_nxt = S_DATA; left_nxt = SSR_DATA_BITS;
                           rd_nxt = cmd_r == CMD_RD_MODE;
                           need_nxt = cmd_r == CMD_WR_MODE;
                           if (cmd_r == CMD_READ || cmd_r == CMD_WRITE) begin
                              seg_nxt = S_ADDR; left_nxt = SSR_ADDR_BITS;
                              sh_nxt = {addr_r, 8'h0};
                              rd_nxt = cmd_r == CMD_READ;
                           end else if (!rd_nxt && !need_nxt) begin
                              st_nxt = H_END;
                              if (cmd_r == CMD_DUAL) lane_nxt = LANE_DUAL;
                              if (cmd_r == CMD_QUAD) lane_nxt = LANE_QUAD;
                              if (cmd_r == CMD_EXIT) lane_nxt = LANE_SINGLE;
                           end
                        end
                        S_ADDR: begin
                           seg_nxt = S_DATA; left_nxt = SSR_DATA_BITS;
                           need_nxt = !rd_r;
                           if (rd_r && lane_r == LANE_DUAL) begin
                              seg_nxt = S_DUMMY;
                              left_nxt = SSR_DUMMY_BITS;
                           end
                        end
                        S_DUMMY: begin
                           seg_nxt = S_DATA; left_nxt = SSR_DATA_BITS;
                        end
                        default: begin
                           rdd_nxt = rx_r; rdv_nxt = rd_r;
                           left_nxt = SSR_DATA_BITS; need_nxt = !rd_r;
                           len_nxt = len_r - 8'h01;
                           if (len_r <= 8'h01) begin
                              st_nxt = H_END; need_nxt = 1'b0;
                           end
                        end
                     endcase
                  end
               end
            end
         end
         H_END: begin
            div_nxt = div_r + 8'h01;
            if (div_r == 8'(SCK_HALF - 1)) begin
               div_nxt = 8'h00; st_nxt = H_IDLE;
            end
         end
         default: st_nxt = H_IDLE;
      endcase
   end

   always_ff @(posedge sys_clk) begin
      meta_r <= link.lane;
      ls_r   <= meta_r;
      if (rst) begin
         st_r <= H_IDLE; seg_r <= S_CMD; lane_r <= LANE_SINGLE;
         div_r <= 8'h00; len_r <= 8'h00; cmd_r <= 8'h00;
         rx_r <= 8'h00; rdd_r <= 8'h00; sh_r <= 32'h0;
         addr_r <= 24'h0; left_r <= 5'h00; sck_r <= 1'b0;
         rd_r <= 1'b0; need_r <= 1'b0; hold_r <= 1'b0; rdv_r <= 1'b0;
      end else begin
         st_r <= st_nxt; seg_r <= seg_nxt; lane_r <= lane_nxt;
         div_r <= div_nxt; len_r <= len_nxt; cmd_r <= cmd_nxt;
         rx_r <= rx_nxt; rdd_r <= rdd_nxt; sh_r <= sh_nxt;
         addr_r <= addr_nxt; left_r <= left_nxt; sck_r <= sck_nxt;
         rd_r <= rd_nxt; need_r <= need_nxt; hold_r <= hold_nxt;
         rdv_r <= rdv_nxt;
      end
   end
endmodule : ssr_host_end
`default_nettype wire

// [rtl/ssr_dev_end.sv]
// Purpose: sram end of the serial link: framing, lanes, pause, array
// Assumes: sck, cs and lanes arrive from pins and are synchronised
// Notes:   sck must stay below a quarter of sys_clk for clean sampling
`default_nettype none
// How it works
// - chip select high: idle, lanes released
// - host pulls select low before commands
// - sample on sck rise, drive after fall
// - pause low suspends, keeps sequence state
// - pause starts when sck low
// - edges ignored while paused, select low
// - resume takes effect when sck low
// - output released and restored with pause
// - quad mode: no pause, pin is lane3
// - dual: lanes 0 and 1 both ways
// - quad uses four lanes; lane2 idle otherwise
// - eight-bit command; deselect ends operation
// - everything shifted most significant first
// - byte mode moves exactly one byte
// - page mode wraps within 32 bytes
// - sequential mode increments to die end
// - die end rolls over to the start of the same die
// - host restarts transfer at second die
// - fixed command code table
// - top five address bits ignored
// - access mode resets to sequential
// - dual read has four dummy clocks
module ssr_dev_end import ssr_pkg::*; #(
   parameter int ADDR_W = SSR_ADDR_W,
   parameter int PAGE_W = SSR_PAGE_W
) (
   // clock and reset
   input  wire logic  sys_clk,
   input  wire logic  rst,
   // link pins
   ssr_link_if.dev    link,
   // status
   output logic [1:0] op_mode,
   output ssr_lane_t  lane_mode,
   output logic       paused,
   output logic       selected
);
   typedef enum logic [2:0] {
      D_CMD, D_ADDR, D_DUMMY, D_WR, D_RD, D_MWR, D_MRD, D_IGN
   } ssr_dph_t;

   ssr_dph_t  ph_r, ph_nxt;
   ssr_lane_t lane_r, lane_nxt;
   logic [5:0]  meta_r, sync_r;
   logic        sck_d_r;
   logic [4:0]  cnt_r, cnt_nxt, cadd, w;
   logic [3:0]  ocnt_r, ocnt_nxt, out_r, out_nxt, slice, en;
   logic [23:0] sh_r, sh_nxt, shin;
   logic [ADDR_W-1:0] addr_r, addr_nxt;
   logic [1:0]  mode_r, mode_nxt;
   logic        rd_r, rd_nxt, bd_r, bd_nxt, pz_r, pz_nxt, go_r, go_nxt;
   logic        cs_s, sck_s, hold_n_s, rise_ok, fall_ok, mem_we;
   logic        byte_like, drive;
   logic [3:0]  lane_s;
   logic [7:0]  rbyte, rsh;
   logic [7:0]  mem_r [0:(1 << ADDR_W) - 1];

   // next address: page wraps, sequential stays in its die
   function automatic logic [ADDR_W-1:0] adv(
      input logic [ADDR_W-1:0] a, input logic [1:0] m);
      if (m == MODE_PAGE) begin
         return {a[ADDR_W-1:PAGE_W], a[PAGE_W-1:0] + 1'b1};
      end
      return {a[ADDR_W-1], a[ADDR_W-2:0] + 1'b1};
   endfunction : adv

   // -------------------------------------------------------------
   // pin synchronisers and sck edge detection
   // -------------------------------------------------------------
   always_ff @(posedge sys_clk) begin
      meta_r  <= {link.cs_n, link.sck, link.lane};
      sync_r  <= meta_r;
      sck_d_r <= sync_r[4];
   end
   assign cs_s     = sync_r[5];
   assign sck_s    = sync_r[4];
   assign lane_s   = sync_r[3:0];
   assign hold_n_s = lane_s[3];
   // pause swallows edges; a pending pause eats its starting fall
   assign rise_ok = !cs_s && !pz_r && sck_s && !sck_d_r;
   assign fall_ok = !cs_s && !pz_r && !pz_nxt && !sck_s && sck_d_r;

   // -------------------------------------------------------------
   // pause tracking
   // -------------------------------------------------------------
   always_comb begin
      pz_nxt = pz_r;
      if (cs_s || lane_r == LANE_QUAD) begin
         pz_nxt = 1'b0;
      end else if (!sck_s) begin
         pz_nxt = !hold_n_s;
      end
   end

   // -------------------------------------------------------------
   // lane shaping of input and output bits
   // -------------------------------------------------------------
   assign rbyte = (ph_r == D_MRD) ? {mode_r, 6'h00} : mem_r[addr_r];
   assign rsh   = rbyte << ocnt_r[2:0];
   always_comb begin
      case (lane_r)
         LANE_DUAL: begin
            w = 5'h02; shin = {sh_r[21:0], lane_s[1:0]};
            slice = {2'h0, rsh[7:6]}; en = 4'h3;
         end
         LANE_QUAD: begin
            w = 5'h04; shin = {sh_r[19:0], lane_s};
            slice = rsh[7:4]; en = 4'hf;
         end
         default: begin
            w = 5'h01; shin = {sh_r[22:0], lane_s[0]};
            slice = {2'h0, rsh[7], 1'b0}; en = 4'h2;
         end
      endcase
   end
   assign cadd = cnt_r + w;
   assign byte_like = mode_r == MODE_BYTE || mode_r == 2'h3;

   // output only while selected reading, cut by a low pause pin outside quad mode;
   // go_r waits for the first fall, as the host owns the lanes till then
   assign drive = !cs_s && (ph_r == D_RD || ph_r == D_MRD) && go_r
               && (hold_n_s || lane_r == LANE_QUAD);
   assign link.dev_o    = out_r;
   assign link.dev_oe_n = ~(en & {4{drive}});
   assign op_mode   = mode_r;
   assign lane_mode = lane_r;
   assign paused    = pz_r;
   assign selected  = !cs_s;

   // -------------------------------------------------------------
   // command, address and data sequencing
   // -------------------------------------------------------------
   always_comb begin
      ph_nxt = ph_r; lane_nxt = lane_r; cnt_nxt = cnt_r;
      ocnt_nxt = ocnt_r; out_nxt = out_r; sh_nxt = sh_r;
      addr_nxt = addr_r; mode_nxt = mode_r; rd_nxt = rd_r;
      bd_nxt = bd_r; go_nxt = go_r; mem_we = 1'b0;
      if (cs_s) begin
         ph_nxt = D_CMD; cnt_nxt = 5'h00;
         ocnt_nxt = 4'h0; bd_nxt = 1'b0; go_nxt = 1'b0;
      end else if (rise_ok) begin
         sh_nxt = shin;
         cnt_nxt = cadd;
         case (ph_r)
            D_CMD: begin
               if (cadd == SSR_CMD_BITS) begin
                  cnt_nxt = 5'h00;
                  ph_nxt = D_IGN;
                  case (shin[7:0])
                     CMD_READ:    ph_nxt = D_ADDR;
                     CMD_WRITE:   ph_nxt = D_ADDR;
                     CMD_RD_MODE: ph_nxt = D_MRD;
                     CMD_WR_MODE: ph_nxt = D_MWR;
                     CMD_DUAL: begin
                        if (lane_r == LANE_SINGLE) lane_nxt = LANE_DUAL;
                     end
                     CMD_QUAD: begin
                        if (lane_r == LANE_SINGLE) lane_nxt = LANE_QUAD;
                     end
                     CMD_EXIT: lane_nxt = LANE_SINGLE;
                     default:  ph_nxt = D_IGN;
                  endcase
                  rd_nxt = shin[7:0] == CMD_READ;
               end
            end
            D_ADDR: begin
               if (cadd == SSR_ADDR_BITS) begin
                  cnt_nxt = 5'h00;
                  addr_nxt = shin[ADDR_W-1:0];
                  ph_nxt = !rd_r ? D_WR
                         : (lane_r == LANE_DUAL) ? D_DUMMY : D_RD;
               end
            end
            D_DUMMY: begin
               if (cadd == SSR_DUMMY_BITS) begin
                  cnt_nxt = 5'h00;
                  ph_nxt = D_RD;
               end
            end
            D_WR: begin
               if (cadd == SSR_DATA_BITS) begin
                  cnt_nxt = 5'h00;
                  mem_we = 1'b1;
                  addr_nxt = adv(addr_r, mode_r);
                  if (byte_like) ph_nxt = D_IGN;
               end
            end
            D_MWR: begin
               if (cadd == SSR_DATA_BITS) begin
                  mode_nxt = shin[7:6];
                  ph_nxt = D_IGN;
               end
            end
            default: cnt_nxt = 5'h00;
         endcase
      end else if (fall_ok && (ph_r == D_RD || ph_r == D_MRD)) begin
         if (bd_r) begin
            ph_nxt = D_IGN;
         end else begin
            out_nxt = slice;
            go_nxt = 1'b1;
            ocnt_nxt = ocnt_r + w[3:0];
            if (ocnt_r + w[3:0] == 4'h8) begin
               ocnt_nxt = 4'h0;
               if (ph_r == D_RD) begin
                  addr_nxt = adv(addr_r, mode_r);
                  bd_nxt = byte_like;
               end
            end
         end
      end
   end

   always_ff @(posedge sys_clk) begin
      if (rst) begin
         ph_r <= D_CMD; lane_r <= LANE_SINGLE;
         cnt_r <= 5'h00; ocnt_r <= 4'h0; out_r <= 4'h0;
         sh_r <= 24'h0; addr_r <= '0; mode_r <= MODE_RST;
         rd_r <= 1'b0; bd_r <= 1'b0; pz_r <= 1'b0; go_r <= 1'b0;
      end else begin
         ph_r <= ph_nxt; lane_r <= lane_nxt;
         cnt_r <= cnt_nxt; ocnt_r <= ocnt_nxt; out_r <= out_nxt;
         sh_r <= sh_nxt; addr_r <= addr_nxt; mode_r <= mode_nxt;
         rd_r <= rd_nxt; bd_r <= bd_nxt; pz_r <= pz_nxt; go_r <= go_nxt;
      end
   end

   // array write, one byte per completed data byte
   always_ff @(posedge sys_clk) begin
      if (mem_we) begin
         mem_r[addr_r] <= shin[7:0];
      end
   end
endmodule : ssr_dev_end
`default_nettype wire

// [bench/ssr_link_properties.sv]
// Purpose: pin checks between host end and sram end
// Assumes: sck half period of 8 sys_clk cycles
// Notes:   sees the link pins only
`default_nettype none
module ssr_link_props (
   // clock and reset
   input wire logic       sys_clk,
   input wire logic       rst,
   // link pins
   input wire logic       cs_n,
   input wire logic       sck,
   input wire logic [3:0] host_o,
   input wire logic [3:0] host_oe_n,
   input wire logic [3:0] dev_o,
   input wire logic [3:0] dev_oe_n,
   input wire logic [3:0] lane
);
   timeunit 1ns;
   timeprecision 1ps;
   // ---------------------------
   // pin relations
   // ---------------------------
   default clocking @(posedge sys_clk); endclocking
   default disable iff (rst);
   property p_idle; cs_n [*6] |-> &dev_oe_n; endproperty
   a_idle: assert property (p_idle) else $error("idle drive");
   property p_start; $fell(cs_n) |-> (&dev_oe_n) [*8]; endproperty
   a_start: assert property (p_start) else $error("early drive");
   property p_fight; &(dev_oe_n | host_oe_n); endproperty
   a_fight: assert property (p_fight) else $error("lane fight");
   property p_edge; $changed(dev_o) && !cs_n |-> !sck; endproperty
   a_edge: assert property (p_edge) else $error("out moved high");
   property p_sel; $rose(sck) |-> !cs_n; endproperty
   a_sel: assert property (p_sel) else $error("clock unselected");
   property p_rst; $fell(rst) |-> cs_n && !sck; endproperty
   a_rst: assert property (p_rst) else $error("select at reset");
   property p_half; $rose(sck) |-> sck [*8] ##1 !sck; endproperty
   a_half: assert property (p_half) else $error("sck half");
   // pause pin low must release the outputs within the sync delay
   property p_hold;
      (!host_oe_n[3] && !lane[3] && !cs_n) [*5] |-> &dev_oe_n;
   endproperty
   a_hold: assert property (p_hold) else $error("drive in pause");
endmodule : ssr_link_props
`default_nettype wire

// [bench/testbench.sv]
// Purpose: host end against sram end, checked by an array model
// Assumes: sck half of 8 cycles, full address width
// Notes:   reads predicted from bytes written earlier
`default_nettype none
module testbench import ssr_pkg::*;;
   timeunit 1ns;
   timeprecision 1ps;
   logic        sys_clk = 1'b0, rst = 1'b1, hold_req = 1'b0;
   logic        req_valid = 1'b0, wr_valid = 1'b0;
   logic        req_ready, wr_ready, rd_valid, paused, sel;
   logic [7:0]  req_cmd = 8'h00, req_len = 8'h00, wr_data = 8'h00;
   logic [7:0]  rd_data, mem [logic [18:0]], exp_q [$];
   logic [23:0] req_addr = 24'h000000;
   logic [1:0]  op_mode, md = MODE_SEQ;
   ssr_lane_t   h_lane, d_lane;
   int          err_count = 0, check_count = 0;
   ssr_link_if lk ();
   ssr_host_end ssr_host_end_i (.sys_clk(sys_clk), .rst(rst), .link(lk),
      .req_valid(req_valid), .req_ready(req_ready), .req_cmd(req_cmd),
      .req_addr(req_addr), .req_len(req_len), .wr_valid(wr_valid),
      .wr_ready(wr_ready), .wr_data(wr_data), .rd_valid(rd_valid),
      .rd_data(rd_data), .hold_req(hold_req), .lane_mode(h_lane));
   ssr_dev_end ssr_dev_end_i (.sys_clk(sys_clk), .rst(rst), .link(lk),
      .op_mode(op_mode), .lane_mode(d_lane), .paused(paused), .selected(sel));
   ssr_link_props ssr_link_props_i (.sys_clk(sys_clk), .rst(rst),
      .cs_n(lk.cs_n), .sck(lk.sck), .host_o(lk.host_o), .lane(lk.lane),
      .host_oe_n(lk.host_oe_n), .dev_o(lk.dev_o), .dev_oe_n(lk.dev_oe_n));
   always #5 sys_clk = ~sys_clk;
   task automatic chk(input logic [7:0] s, input logic [7:0] e);
      check_count++;
      if (s !== e) begin
         err_count++;
         $display("unexpected at %0t: got %h want %h", $time, s, e);
      end
   endtask : chk
   // next array address as the current access mode steps it
   function automatic logic [18:0] nx(input logic [18:0] p);
      case (md)
         MODE_PAGE: return {p[18:5], p[4:0] + 5'h01};
         MODE_SEQ:  return {p[18], p[17:0] + 18'h00001};
         default:   return p;
      endcase
   endfunction : nx
   // one frame: data into the fifo first, since an empty fifo stalls sck
   task automatic xfer(input logic [7:0] c, input logic [23:0] a,
                       input int n, input logic [7:0] d);
      logic [18:0] p;
      logic [7:0]  b;
      int          k;
      p = a[18:0];
      for (k = 0; k < n; k++) begin
         // byte mode: a second byte reads the released, pulled-up lane
         if (c == CMD_READ)
            exp_q.push_back((md == MODE_BYTE && k > 0) ? 8'hff : mem[p]);
         if (c == CMD_RD_MODE) exp_q.push_back({md, 6'h00});
         if (c == CMD_WRITE || c == CMD_WR_MODE) begin
            b = (c == CMD_WRITE) ? 8'($urandom) : d;
            if (c == CMD_WRITE) mem[p] = b;
            wr_valid <= 1'b1;
            wr_data <= b;
            do @(posedge sys_clk); while (wr_ready !== 1'b1);
         end
         p = nx(p);
      end
      wr_valid <= 1'b0;
      #1;
      if (c == CMD_WRITE && n == 8) chk(8'(wr_ready), 8'h00);
      @(posedge sys_clk);
      req_valid <= 1'b1;
      req_cmd <= c;
      req_addr <= a;
      req_len <= 8'(n);
      do @(posedge sys_clk); while (req_ready !== 1'b1);
      req_valid <= 1'b0;
      @(posedge sys_clk);
      for (k = 0; k < 30000 && req_ready !== 1'b1; k++) @(posedge sys_clk);
      if (req_ready !== 1'b1) err_count++;   // a hung frame counts
      if (c == CMD_WR_MODE) md = d[7:6];
      chk(8'(op_mode), 8'(md));
      chk(8'(sel), 8'h00);
   endtask : xfer
   task automatic stop_test();
      $display("mismatches %0d, checks %0d", err_count, check_count);
      if (err_count == 0 && check_count > 0)
         $display("All checks passed");
      else
         $display("Checks failed");
      $finish;
   endtask : stop_test
   // oldest prediction against each read byte
   always @(posedge sys_clk) begin
      if (rd_valid === 1'b1) begin
         if (exp_q.size() == 0) chk(8'h00, 8'h01);
         else chk(rd_data, exp_q.pop_front());
      end
   end
   initial begin
      repeat (80000) @(posedge sys_clk);
      err_count++;
      stop_test();
   end
   initial begin
      logic [23:0] ra;
      void'($urandom(32'h00af));
      repeat (6) @(posedge sys_clk);
      rst <= 1'b0;
      @(posedge sys_clk);
      xfer(CMD_RD_MODE, 24'h0, 1, 8'h00);
      xfer(CMD_WRITE, 24'hfbfffc, 8, 8'h00);
      fork
         xfer(CMD_READ, 24'h000000, 4, 8'h00);
         begin
            repeat (600) @(posedge sys_clk);
            hold_req <= 1'b1;
            repeat (40) @(posedge sys_clk);
            chk(8'(paused), 8'h01);
            hold_req <= 1'b0;
         end
      join
      xfer(CMD_READ, 24'h03fffc, 4, 8'h00);
      xfer(CMD_WR_MODE, 24'h0, 1, {MODE_PAGE, 6'h00});
      xfer(CMD_WRITE, 24'h00051e, 4, 8'h00);
      xfer(CMD_READ, 24'h000500, 2, 8'h00);
      xfer(CMD_WR_MODE, 24'h0, 1, {MODE_BYTE, 6'h00});
      xfer(CMD_READ, 24'h00051f, 2, 8'h00);
      xfer(CMD_RD_MODE, 24'h0, 1, 8'h00);
      xfer(CMD_WR_MODE, 24'h0, 1, {MODE_SEQ, 6'h00});
      for (int i = 0; i < 2; i++) begin
         ra = 24'($urandom);
         xfer(i ? CMD_QUAD : CMD_DUAL, 24'h0, 0, 8'h00);
         chk(8'(d_lane), i ? 8'(LANE_QUAD) : 8'(LANE_DUAL));
         xfer(CMD_WRITE, ra, 5, 8'h00);
         xfer(CMD_READ, ra, 5, 8'h00);
         xfer(CMD_EXIT, 24'h0, 0, 8'h00);
         chk(8'(h_lane), 8'(LANE_SINGLE));
         chk(8'(d_lane), 8'(LANE_SINGLE));
      end
      chk(8'(exp_q.size()), 8'h00);
      stop_test();
   end
endmodule : testbench
`default_nettype wire
